// ===== qsc_consts.svh
// constants for the quad channel converter serial control block
`ifndef QSC_CONSTS_SVH
`define QSC_CONSTS_SVH
`define QSC_CONV_CLOCKS    5'd16   // serial clocks per conversion
`define QSC_TRACK_LAST     5'd3    // last clock spent tracking
`define QSC_HOLD_FIRST     5'd4    // falling edge that enters hold
`define QSC_MSB_CLOCK      5'd5    // falling edge that drives the result msb
`define QSC_LSB_CLOCK      5'd14   // falling edge that drives the result lsb
`define QSC_CTL_BITS       5'd8    // rising edges that sample the control line
`define QSC_SEL_HI         4       // upper channel select field bit
`define QSC_SEL_LO         3       // lower channel select field bit
`define QSC_CTL_RESET      8'h00   // control word after reset
`define QSC_CHAN_DEFAULT   2'h0    // input one
`define QSC_RES_W          10      // result width
`endif

// ===== qsc_pkg.sv
// types shared by the serial control block
package qsc_pkg;
	// conversion phase as seen by the analog core
	typedef enum logic [1:0] {
		QSC_OFF,    // chip select high, fully powered down
		QSC_TRACK,  // input connected to sampling capacitor
		QSC_HOLD,   // successive approximation running
		QSC_NAP     // automatic power down between conversions
	} qsc_phase_t;
endpackage : qsc_pkg

// ===== qsc_pins_if.sv
// carrier for the synchronised serial pins
`timescale 1ns/100ps
`default_nettype none
interface qsc_pins_if;
	logic cs_n_s;  // chip select, synchronised, active low
	logic sclk_s;  // serial clock, synchronised
	logic din_s;   // control input, synchronised
	modport sync (output cs_n_s, output sclk_s, output din_s);
	modport core (input cs_n_s, input sclk_s, input din_s);
endinterface : qsc_pins_if
`default_nettype wire

// ===== qsc_pin_sync.sv
// two flip-flop synchronisers for the serial pins
`timescale 1ns/100ps
`default_nettype none
module qsc_pin_sync (
	input  wire logic  clk,     // system clock
	input  wire logic  arst_n,  // async reset, active low
	input  wire logic  cs_n,    // chip select pin
	input  wire logic  sclk,    // serial clock pin
	input  wire logic  din,     // control input pin
	qsc_pins_if.sync   pins     // synchronised pins
);
	logic [2:0] meta_r;  // first stage, read only by second stage
	logic [2:0] sync_r;  // second stage

	// chip select resets high so the block starts powered down
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= 3'h4;
			sync_r <= 3'h4;
		end else begin
			meta_r <= {cs_n, sclk, din};
			sync_r <= meta_r;
		end
	end

	assign pins.cs_n_s = sync_r[2];
	assign pins.sclk_s = sync_r[1];
	assign pins.din_s  = sync_r[0];
endmodule : qsc_pin_sync
`default_nettype wire

// ===== qsc_serial_ctrl.sv
// serial control of the quad channel converter
//
// Behaviour
// (R1) bits 7-6 and 2-0 are ignored
// (R2) bits 4-3 select next conversion's channel
// (R3) bit 5 ignored; bits 4:3 pick input
// (R4) result is 10-bit straight binary
// (R5) active while chip select low, else off
// (R6) nap after 16th fall until next 1st
// (R7) sixteen clocks per conversion, back to back
// (R8) keep converting while chip select low
// (R9) host keeps serial clock at most 16 MHz
// (R10) first 8 rising edges sample control, msb first
// (R11) output released while chip select high
// (R12) track three clocks; result msb from clock 5
// (R13) no dummy conversion; first uses input one
// (R14) zeros on non-result bit positions
`timescale 1ns/100ps
`default_nettype none
`include "qsc_consts.svh"
module qsc_serial_ctrl (
	input  wire logic                  clk,            // 10 MHz system clock
	input  wire logic                  arst_n,         // async reset, active low
	input  wire logic                  cs_n,           // chip select pin, active low
	input  wire logic                  sclk,           // serial clock pin
	input  wire logic                  din,            // control input pin
	input  wire logic [`QSC_RES_W-1:0] conv_code,      // code from the approximation core
	output logic                       dout,           // serial result out
	output logic                       dout_oe,        // result pin driven when high
	output logic [1:0]                 chan_sel,       // analog mux select, 0 is input one
	output logic                       track,          // sampling switch closed
	output logic                       power_down,     // analog core powered down
	output logic [7:0]                 ctl_word,       // last full control word
	output logic [`QSC_RES_W-1:0]      result          // last sampled result code
);
	qsc_pins_if pins ();  // synchronised pins

	qsc_pin_sync u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.cs_n   (cs_n),
		.sclk   (sclk),
		.din    (din),
		.pins   (pins)
	);

	logic                  sclk_d_r;        // previous serial clock level
	logic                  cs_n_d_r;        // previous chip select level
	logic [4:0]            fall_cnt_r;      // falling edges in this conversion
	logic [4:0]            rise_cnt_r;      // rising edges in this conversion
	logic [7:0]            shift_r;         // control word being shifted in
	logic [1:0]            pend_chan_r;     // channel for the next conversion
	qsc_pkg::qsc_phase_t   phase_r;         // analog phase
	qsc_pkg::qsc_phase_t   phase_nxt;       // analog phase after this cycle
	logic                  track_r;         // sampling switch, registered
	logic                  power_down_r;    // core power down, registered
	logic [`QSC_RES_W-1:0] result_r;        // held conversion result
	logic                  dout_r;          // result line level
	logic                  dout_oe_r;       // result line enable
	logic [1:0]            chan_r;          // applied channel
	logic [7:0]            ctl_r;           // last complete control word

	logic frame;      // chip select low
	logic cs_fall;    // frame opens this cycle
	logic sclk_fall;  // serial clock fell inside a frame
	logic sclk_rise;  // serial clock rose inside a frame
	logic fall_ev;    // internal falling edge, including the one a frame opens with
	logic conv_start; // falling edge that opens a conversion
	logic [4:0] fall_nxt;  // falling count after this event

	// detection: gate the serial clock off outside a frame
	assign frame      = ~pins.cs_n_s;                            // [R5]
	assign cs_fall    = cs_n_d_r & ~pins.cs_n_s;
	assign sclk_fall  = frame & sclk_d_r & ~pins.sclk_s;
	assign sclk_rise  = frame & ~sclk_d_r & pins.sclk_s;
	// a frame opened with the clock already low counts as the first fall
	assign fall_ev    = (sclk_fall & ~cs_fall) | (cs_fall & ~pins.sclk_s);
	// after the 16th fall the next fall opens a fresh conversion
	assign conv_start = fall_ev & ((fall_cnt_r == 5'd0) ||
		(fall_cnt_r == `QSC_CONV_CLOCKS));                       // [R7] [R8]
	assign fall_nxt   = conv_start ? 5'd1 : fall_cnt_r + 5'd1;

	// edge history
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_d_r <= 1'b0;
			cs_n_d_r <= 1'b1;
		end else begin
			sclk_d_r <= pins.sclk_s;
			cs_n_d_r <= pins.cs_n_s;
		end
	end

	// falling edge counter, cleared whenever the frame closes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fall_cnt_r <= 5'd0;
		end else if (!frame) begin
			fall_cnt_r <= 5'd0;
		end else if (fall_ev) begin
			fall_cnt_r <= fall_nxt;                              // [R7]
		end
	end

	// rising edge counter, restarted by each conversion's first fall
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rise_cnt_r <= 5'd0;
		end else if (!frame || conv_start) begin
			rise_cnt_r <= 5'd0;
		end else if (sclk_rise && rise_cnt_r != `QSC_CONV_CLOCKS) begin
			rise_cnt_r <= rise_cnt_r + 5'd1;
		end
	end

	// control word shift, msb first, only on the first eight rises
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_r <= `QSC_CTL_RESET;
			ctl_r   <= `QSC_CTL_RESET;
		end else if (sclk_rise && fall_cnt_r != 5'd0 && rise_cnt_r < `QSC_CTL_BITS) begin
			shift_r <= {shift_r[6:0], pins.din_s};               // [R10]
			if (rise_cnt_r == `QSC_CTL_BITS - 5'd1) begin
				ctl_r <= {shift_r[6:0], pins.din_s};
			end
		end
	end

	// pending channel: only bits 4:3 matter, the rest never reach it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_chan_r <= `QSC_CHAN_DEFAULT;                    // [R13]
		end else if (sclk_rise && fall_cnt_r != 5'd0 &&
			rise_cnt_r == `QSC_CTL_BITS - 5'd1) begin
			pend_chan_r <= shift_r[`QSC_SEL_HI-1:`QSC_SEL_LO-1]; // [R1] [R2] [R3]
		end
	end

	// channel changes only when a new track phase opens
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chan_r <= `QSC_CHAN_DEFAULT;                         // [R13]
		end else if (conv_start) begin
			chan_r <= pend_chan_r;                               // [R2]
		end
	end

	// next phase: track for three clocks, hold for twelve, then nap
	always_comb begin
		phase_nxt = phase_r;
		if (!frame) begin
			phase_nxt = qsc_pkg::QSC_OFF;                        // [R5]
		end else if (fall_ev) begin
			case (fall_nxt)
				5'd1, 5'd2, 5'd3: phase_nxt = qsc_pkg::QSC_TRACK; // [R12] [R6]
				`QSC_CONV_CLOCKS: phase_nxt = qsc_pkg::QSC_NAP;   // [R6]
				default:          phase_nxt = qsc_pkg::QSC_HOLD;  // [R12]
			endcase
		end
	end

	// analog phase register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_r <= qsc_pkg::QSC_OFF;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// controls decoded ahead of the flop, so the analog pins never glitch
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			track_r      <= 1'b0;
			power_down_r <= 1'b1;
		end else begin
			track_r      <= (phase_nxt == qsc_pkg::QSC_TRACK);    // [R12]
			power_down_r <= (phase_nxt == qsc_pkg::QSC_OFF) ||
				(phase_nxt == qsc_pkg::QSC_NAP);                 // [R5] [R6]
		end
	end

	// result capture at entry to hold; code passes through unchanged
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			result_r <= '0;
		end else if (fall_ev && !conv_start && fall_nxt == `QSC_HOLD_FIRST) begin
			result_r <= conv_code;                               // [R4]
		end
	end

	// serial output changes on falls; msb goes out at the 5th fall so the
	// host takes it at the 5th rise, from the code held since hold entry
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dout_r <= 1'b0;
		end else if (!frame) begin
			dout_r <= 1'b0;
		end else if (fall_ev) begin
			if (conv_start) begin
				dout_r <= 1'b0;                                  // [R14]
			end else if (fall_nxt >= `QSC_MSB_CLOCK && fall_nxt <= `QSC_LSB_CLOCK) begin
				dout_r <= result_r[4'(`QSC_LSB_CLOCK - fall_nxt)]; // [R12]
			end else begin
				dout_r <= 1'b0;                                  // [R14]
			end
		end
	end

	// output enable follows chip select alone
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dout_oe_r <= 1'b0;
		end else begin
			dout_oe_r <= frame;                                  // [R11]
		end
	end

	// the host's clock limit is its own; at 10 MHz sampling a 16 MHz
	// serial clock would alias, so edges are only seen below ~5 MHz [R9]
	assign dout       = dout_r;
	assign dout_oe    = dout_oe_r;
	assign chan_sel   = chan_r;
	assign ctl_word   = ctl_r;
	assign result     = result_r;
	assign track      = track_r;
	assign power_down = power_down_r;                            // [R5] [R6]
endmodule : qsc_serial_ctrl
`default_nettype wire

// ===== qsc_serial_ctrl_assertions.sv
// port level assertions for the serial control block
`timescale 1ns/100ps
`default_nettype none
`include "qsc_consts.svh"
module qsc_serial_ctrl_assertions (
	input wire logic                  clk,        // clock
	input wire logic                  arst_n,     // reset
	input wire logic                  cs_n,       // select
	input wire logic                  sclk,       // serial clock
	input wire logic [`QSC_RES_W-1:0] conv_code,  // core code
	input wire logic                  dout,       // result line
	input wire logic                  dout_oe,    // line enable
	input wire logic [1:0]            chan_sel,   // mux select
	input wire logic                  track,      // tracking
	input wire logic                  power_down, // core off
	input wire logic [7:0]            ctl_word,   // control word
	input wire logic [`QSC_RES_W-1:0] result      // held code
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// six cycles covers the two flop synchroniser plus register
	a_oe_released: assert property (cs_n [*6] |-> !dout_oe)
		else $error("line driven while deselected");
	a_oe_driven: assert property (!cs_n [*6] |-> dout_oe)
		else $error("line idle while selected");
	a_core_off: assert property (cs_n [*6] |-> power_down && !track)
		else $error("core awake while deselected");
	a_frame_wakes: assert property ($fell(cs_n) && !sclk ##1 (!cs_n && !sclk) [*4] |-> track && !power_down)
		else $error("no tracking after select");
	a_track_quiet: assert property (track |-> !dout)
		else $error("line high while tracking");
	a_nap_quiet: assert property ($rose(power_down) && !cs_n |-> !dout && dout_oe)
		else $error("line high entering nap");
	a_chan_at_start: assert property ($changed(chan_sel) |-> track)
		else $error("channel moved outside track");
	a_ctl_in_hold: assert property ($changed(ctl_word) |-> !track && !power_down)
		else $error("control word outside hold");
	a_capture_code: assert property ($fell(track) && !power_down |-> result == conv_code && !dout)
		else $error("hold entry missed code or drove early");
	a_nap_bounded: assert property ($rose(power_down) && !cs_n |-> ##[1:300] (!power_down || cs_n))
		else $error("conversions stopped in frame");
	c_hold: cover property ($fell(track) && !power_down);
	c_nap: cover property ($rose(power_down) && !cs_n);
	c_chan: cover property ($changed(chan_sel));
endmodule : qsc_serial_ctrl_assertions
bind qsc_serial_ctrl qsc_serial_ctrl_assertions i_chk (.clk, .arst_n, .cs_n, .sclk, .conv_code,
	.dout, .dout_oe, .chan_sel, .track, .power_down, .ctl_word, .result);
`default_nettype wire

// ===== qsc_host_model.sv
// host serial port model: select, serial clock and control line
`timescale 1ns/100ps
`default_nettype none
module qsc_host_model (
	input  wire logic clk,  // system clock
	input  wire logic dout, // result line
	output var logic  cs_n, // select, active low
	output var logic  sclk, // serial clock, parked low
	output var logic  din   // control line
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b0;
	end
	// released line toggles so no stale level reads as data
	always @(negedge clk) if (cs_n) din <= ~din;
	// sclk parked low, so the select fall is the first fall
	task open_frame();
		cs_n = 1'b0;
		@(negedge clk);
	endtask : open_frame
	// 16 clocks, word msb first on rises 1-8, result read at each rise
	task conv(input logic [7:0] w, output logic [15:0] rx);
		for (int i = 0; i < 16; i++) begin
			din = (i < 8) ? w[7-i] : ~din;
			repeat (6) @(negedge clk); // low phase well above sync delay
			rx[15-i] = dout;
			sclk = 1'b1;
			repeat (4) @(negedge clk);
			sclk = 1'b0; // also first fall of the next conversion
		end
	endtask : conv
	task close_frame();
		repeat (6) @(negedge clk);
		cs_n = 1'b1;
	endtask : close_frame
endmodule : qsc_host_model
`default_nettype wire

// ===== tb_qsc_serial_ctrl.sv
// testbench for the serial control block
`timescale 1ns/100ps
`default_nettype none
`include "qsc_consts.svh"
module tb_qsc_serial_ctrl;
	logic                  clk, arst_n, cs_n, sclk, din, dout, dout_oe, track, power_down;
	logic [1:0]            chan_sel, exp_chan;
	logic [7:0]            ctl_word;
	logic [`QSC_RES_W-1:0] conv_code, result;
	logic [15:0]           rx;
	logic                  dout_line;  // result line as the host sees it
	logic [7:0]            words [$];
	int                    miscompares, checks;
	// code per input, both extremes included
	logic [`QSC_RES_W-1:0] codes [4] = '{10'h000, 10'h3ff, 10'h2aa, 10'h155};
	qsc_serial_ctrl i_dut (.clk, .arst_n, .cs_n, .sclk, .din, .conv_code, .dout, .dout_oe,
		.chan_sel, .track, .power_down, .ctl_word, .result);
	// a released line shows the inverse, so a stale level never reads as data
	assign dout_line = dout_oe ? dout : ~dout;
	qsc_host_model i_host (.clk, .dout(dout_line), .cs_n, .sclk, .din);
	always #50 clk = ~clk;
	// analog core stand-in follows the mux
	always @(negedge clk) conv_code <= codes[chan_sel];
	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask : chk
	task do_reset();
		arst_n = 1'b0;
		repeat (6) @(negedge clk);
		chk("reset state", 16'h0, {chan_sel, track, dout_oe, ctl_word, ~power_down, dout, 2'h0});
		arst_n = 1'b1;
		repeat (4) @(negedge clk); // synchroniser settles first
		exp_chan = 2'h0;
	endtask : do_reset
	// one frame of back to back conversions, channel taken from the word before
	task frame(input string name);
		i_host.open_frame();
		foreach (words[k]) begin
			i_host.conv(words[k], rx);
			chk("serial result", {4'h0, codes[exp_chan], 2'h0}, rx);
			chk("held result", 16'(codes[exp_chan]), 16'(result));
			chk("control word", 16'(words[k]), 16'(ctl_word));
			chk("enable in frame", 16'h1, 16'(dout_oe));
			exp_chan = words[k][4:3]; // bits 7-6, 5, 2-0 ignored
		end
		i_host.close_frame();
		repeat (8) @(negedge clk);
		chk("idle state", 16'h1, {dout_oe, power_down});
		$display("test %s done", name);
	endtask : frame
	task print_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		conv_code = '0;
		do_reset();
		words = '{8'h28, 8'h10, 8'hff, 8'hc7, 8'h18};
		frame("back_to_back");
		words = '{8'h10};
		frame("pending_channel");
		do_reset();
		words = '{8'h08, 8'he7};
		frame("after_reset");
		print_verdict();
	end
	initial begin
		repeat (6000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
endmodule : tb_qsc_serial_ctrl
`default_nettype wire
